// File: logic/cnt16_pkg.sv
/*
 * Shared constants for the 16-bit counter with input capture: I/O
 * addresses, control bit positions, waveform mode codes, reset values
 * and capture filter length.
 * Assumes an 8-bit I/O bus with an 8-bit address; addresses are local.
 */
package cnt16_pkg;

    // I/O locations of the block
    localparam logic [7:0] ADDR_CTRL_A     = 8'h00;
    localparam logic [7:0] ADDR_CTRL_B     = 8'h01;
    localparam logic [7:0] ADDR_CNT_LOW    = 8'h02;
    localparam logic [7:0] ADDR_CNT_HIGH   = 8'h03;
    localparam logic [7:0] ADDR_CMPA_LOW   = 8'h04;
    localparam logic [7:0] ADDR_CMPA_HIGH  = 8'h05;
    localparam logic [7:0] ADDR_CMPB_LOW   = 8'h06;
    localparam logic [7:0] ADDR_CMPB_HIGH  = 8'h07;
    localparam logic [7:0] ADDR_CAP_LOW    = 8'h08;
    localparam logic [7:0] ADDR_CAP_HIGH   = 8'h09;
    localparam logic [7:0] ADDR_IRQ_MASK   = 8'h0a;
    localparam logic [7:0] ADDR_IRQ_FLAGS  = 8'h0b;
    localparam logic [7:0] ADDR_COMP_CTRL  = 8'h0c;

    // Field positions in timer_ctrl_a / timer_ctrl_b
    localparam int WGM_LOW_POS    = 0; // ctrl_a bits 1:0 = mode bits 1:0
    localparam int WGM_HIGH_POS   = 3; // ctrl_b bits 4:3 = mode bits 3:2
    localparam int CLK_SEL_POS    = 0; // ctrl_b bits 2:0
    localparam int EDGE_SEL_POS   = 6; // ctrl_b: 1 = rising edge
    localparam int FILTER_EN_POS  = 7; // ctrl_b

    // Flag and mask bit positions, comparator select position
    localparam int OVF_BIT        = 0;
    localparam int CAP_BIT        = 1;
    localparam int COMP_SEL_POS   = 2;

    // Waveform mode codes
    localparam logic [3:0] WM_NORMAL     = 4'h0;
    localparam logic [3:0] WM_PC8        = 4'h1;
    localparam logic [3:0] WM_PC9        = 4'h2;
    localparam logic [3:0] WM_PC10       = 4'h3;
    localparam logic [3:0] WM_CTC_CMPA   = 4'h4;
    localparam logic [3:0] WM_FAST8      = 4'h5;
    localparam logic [3:0] WM_FAST9      = 4'h6;
    localparam logic [3:0] WM_FAST10     = 4'h7;
    localparam logic [3:0] WM_PFC_CAP    = 4'h8;
    localparam logic [3:0] WM_PFC_CMPA   = 4'h9;
    localparam logic [3:0] WM_PC_CAP     = 4'ha;
    localparam logic [3:0] WM_PC_CMPA    = 4'hb;
    localparam logic [3:0] WM_CTC_CAP    = 4'hc;
    localparam logic [3:0] WM_RESERVED   = 4'hd;
    localparam logic [3:0] WM_FAST_CAP   = 4'he;
    localparam logic [3:0] WM_FAST_CMPA  = 4'hf;

    // Fixed top values and counter limits
    localparam logic [15:0] TOP_8BIT     = 16'h00ff;
    localparam logic [15:0] TOP_9BIT     = 16'h01ff;
    localparam logic [15:0] TOP_10BIT    = 16'h03ff;
    localparam logic [15:0] CNT_MAX      = 16'hffff;
    localparam logic [15:0] CNT_BOTTOM   = 16'h0000;
    localparam logic [15:0] CNT_STEP     = 16'h0001;

    // Reset values
    localparam logic [15:0] RST_WORD     = 16'h0000;
    localparam logic [7:0]  RST_BYTE     = 8'h00;

    // Capture filter: samples that must agree
    localparam int FILTER_SAMPLES = 4;

endpackage : cnt16_pkg

// File: logic/capture_filter.sv
/*
 * Capture input conditioner: two-flop synchroniser followed by an
 * optional agreement filter on the system clock.
 * Assumes raw_in is asynchronous to clk; output is a level on clk.
 */
`timescale 1ns/1ps
module capture_filter
    import cnt16_pkg::*;
(
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic ce,
    input  wire logic raw_in,
    input  wire logic filter_en,
    output logic      level_out
);

    typedef struct packed {
        logic                      sync1;
        logic                      sync2;
        logic [FILTER_SAMPLES-1:0] hist;
        logic                      level;
    } filt_state_t;

    filt_state_t s_q;
    filt_state_t s_d;

    // Filter only looks at the second sync stage, never the first
    always_comb begin
        s_d       = s_q;
        s_d.sync1 = raw_in;
        s_d.sync2 = s_q.sync1;
        s_d.hist  = {s_q.hist[FILTER_SAMPLES-2:0], s_q.sync2};
        if (!filter_en) begin
            s_d.level = s_q.sync2;
        end else if (&s_q.hist) begin
            s_d.level = 1'b1;
        end else if (~|s_q.hist) begin
            s_d.level = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign level_out = s_q.level;

endmodule : capture_filter

// File: logic/cnt16_capture.sv
/*
 * 16-bit up/down timer counter with input capture, compare storage and
 * a shared high-byte holding register, reached over an 8-bit I/O bus.
 * Assumes timer_tick is a one-cycle enable from a prescaler on clk and
 * that capture_pin and comparator_output are asynchronous levels.
 * Limitation: compare registers load directly on the low write, with
 * no double buffering at TOP or BOTTOM.
 */
`timescale 1ns/1ps
// Contract
// - Counter is visible as a high and a low 8-bit location.
// - Counter high-byte accesses go to the shared holding register.
// - Low read fills holding byte; low write loads holding into counter.
// - Holding byte persists after low writes, allowing shared high bytes.
// - Each tick clears, increments or decrements per mode and direction.
// - Counter steps only on tick; clock select zero stops it.
// - Counter is readable and writable whether or not ticking.
// - A counter write beats a coincident count or clear.
// - Four-bit waveform mode, split over both control registers, sets sequence.
// - Indicate TOP at sequence maximum and BOTTOM at zero.
// - Overflow flag set at mode-defined point; usable as interrupt.
// - Matching edge on pin or comparator copies counter into capture.
// - Capture flag sets in the same cycle as the copy.
// - Capture flag requests interrupt when enabled; cleared on service.
// - Writing one clears capture flag; zero leaves it.
// - Capture low read first fills holding; high read returns holding.
// - Capture writable only in capture-as-TOP modes, high then low.
// - Comparator select switches trigger; software clears resulting flag.
// - Capture input active except in capture-as-TOP modes.
// - With filter on, output changes after four agreeing samples.
// - Filter enable in control B adds four clocks, system clocked.
// - Compare register reads bypass the holding register entirely.
module cnt16_capture
    import cnt16_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        ce,
    input  wire logic [7:0]  io_addr,
    input  wire logic        io_rd,
    input  wire logic        io_wr,
    input  wire logic [7:0]  io_wdata,
    output logic      [7:0]  io_rdata,
    input  wire logic        timer_tick,
    output logic      [2:0]  clock_select_field,
    output logic      [3:0]  waveform_mode_field,
    input  wire logic        capture_pin,
    input  wire logic        comparator_output,
    output logic             capture_irq,
    output logic             overflow_irq,
    input  wire logic        capture_irq_ack,
    input  wire logic        overflow_irq_ack,
    output logic      [15:0] counter_value,
    output logic             top_hit,
    output logic             bottom_hit
);

    typedef struct packed {
        logic [15:0] cnt;
        logic        dir_up;
        logic [15:0] cap;
        logic [15:0] cmpa;
        logic [15:0] cmpb;
        logic [7:0]  hold;
        logic [7:0]  ctrl_a;
        logic [7:0]  ctrl_b;
        logic [1:0]  mask;
        logic        ovf;
        logic        capf;
        logic        comp_sel;
        logic        edge_prev;
        logic [7:0]  rdata;
    } timer_state_t;

    timer_state_t s_q;
    timer_state_t s_d;

    logic [3:0]  mode;
    logic [15:0] top_val;
    logic        dual_slope;
    logic        cap_is_top;
    logic        fast_pwm;
    logic        tick_en;
    logic        cap_src;
    logic        cap_level;
    logic        cap_event;
    logic        cnt_wr;
    logic        rd_low_cnt;
    logic        rd_low_cap;
    logic        ovf_set;

    assign mode = {s_q.ctrl_b[WGM_HIGH_POS+1:WGM_HIGH_POS],
                   s_q.ctrl_a[WGM_LOW_POS+1:WGM_LOW_POS]};

    // Mode decode: top source, slope and capture use
    always_comb begin
        top_val    = CNT_MAX;
        dual_slope = 1'b0;
        cap_is_top = 1'b0;
        fast_pwm   = 1'b0;
        unique case (mode)
            WM_NORMAL, WM_RESERVED: top_val = CNT_MAX;
            WM_PC8: begin
                top_val    = TOP_8BIT;
                dual_slope = 1'b1;
            end
            WM_PC9: begin
                top_val    = TOP_9BIT;
                dual_slope = 1'b1;
            end
            WM_PC10: begin
                top_val    = TOP_10BIT;
                dual_slope = 1'b1;
            end
            WM_CTC_CMPA: top_val = s_q.cmpa;
            WM_FAST8: begin
                top_val  = TOP_8BIT;
                fast_pwm = 1'b1;
            end
            WM_FAST9: begin
                top_val  = TOP_9BIT;
                fast_pwm = 1'b1;
            end
            WM_FAST10: begin
                top_val  = TOP_10BIT;
                fast_pwm = 1'b1;
            end
            WM_PFC_CAP, WM_PC_CAP: begin
                top_val    = s_q.cap;
                dual_slope = 1'b1;
                cap_is_top = 1'b1;
            end
            WM_PFC_CMPA, WM_PC_CMPA: begin
                top_val    = s_q.cmpa;
                dual_slope = 1'b1;
            end
            WM_CTC_CAP: begin
                top_val    = s_q.cap;
                cap_is_top = 1'b1;
            end
            WM_FAST_CAP: begin
                top_val    = s_q.cap;
                fast_pwm   = 1'b1;
                cap_is_top = 1'b1;
            end
            WM_FAST_CMPA: begin
                top_val  = s_q.cmpa;
                fast_pwm = 1'b1;
            end
        endcase
    end

    assign tick_en = timer_tick &&
        (s_q.ctrl_b[CLK_SEL_POS+2:CLK_SEL_POS] != 3'h0);

    assign cap_src = s_q.comp_sel ? comparator_output : capture_pin;

    // Source switch happens before the filter, so it may look like an edge
    capture_filter u_filter (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .ce        (ce),
        .raw_in    (cap_src),
        .filter_en (s_q.ctrl_b[FILTER_EN_POS]),
        .level_out (cap_level)
    );

    // Previous level tracks in every mode, so leaving a capture-as-TOP
    // mode never shows a stale edge
    // edge matching selection
    assign cap_event = !cap_is_top &&
        (cap_level != s_q.edge_prev) &&
        (cap_level == s_q.ctrl_b[EDGE_SEL_POS]);

    assign cnt_wr     = io_wr && (io_addr == ADDR_CNT_LOW);
    assign rd_low_cnt = io_rd && (io_addr == ADDR_CNT_LOW);
    assign rd_low_cap = io_rd && (io_addr == ADDR_CAP_LOW);

    // Next-state logic: bus side effects, counting, capture, flags
    always_comb begin
        s_d           = s_q;
        s_d.edge_prev = cap_level;
        ovf_set       = 1'b0;

        if (tick_en && !cnt_wr) begin
            if (dual_slope) begin
                if (s_q.dir_up) begin
                    if (s_q.cnt >= top_val) begin
                        s_d.dir_up = 1'b0;
                        s_d.cnt    = s_q.cnt - CNT_STEP;
                    end else begin
                        s_d.cnt = s_q.cnt + CNT_STEP;
                    end
                end else if (s_q.cnt == CNT_BOTTOM) begin
                    // Direction resets to down, so a first tick at zero
                    // turns upward and raises the overflow flag
                    s_d.dir_up = 1'b1;
                    s_d.cnt    = s_q.cnt + CNT_STEP;
                    ovf_set    = 1'b1;
                end else begin
                    s_d.cnt = s_q.cnt - CNT_STEP;
                end
            end else begin
                s_d.dir_up = 1'b1;
                // Clear at TOP; past TOP it runs on and wraps at MAX
                if (s_q.cnt == top_val) begin
                    s_d.cnt = CNT_BOTTOM;
                end else begin
                    s_d.cnt = s_q.cnt + CNT_STEP;
                end
                if (fast_pwm ? (s_q.cnt == top_val)
                             : (s_q.cnt == CNT_MAX)) begin
                    ovf_set = 1'b1;
                end
            end
        end

        // Ack clears; a same-cycle overflow set is applied later
        if (overflow_irq_ack) begin
            s_d.ovf = 1'b0;
        end
        if (capture_irq_ack) begin
            s_d.capf = 1'b0;
        end

        // One holding byte serves all 16-bit registers, so an access
        // interleaved from another context corrupts a byte pair
        // high accesses use holding
        if (io_wr) begin
            unique case (io_addr)
                ADDR_CTRL_A:    s_d.ctrl_a = io_wdata;
                ADDR_CTRL_B:    s_d.ctrl_b = io_wdata;
                ADDR_CNT_LOW:   s_d.cnt    = {s_q.hold, io_wdata};
                ADDR_CMPA_LOW:  s_d.cmpa   = {s_q.hold, io_wdata};
                ADDR_CMPB_LOW:  s_d.cmpb   = {s_q.hold, io_wdata};
                ADDR_CNT_HIGH, ADDR_CMPA_HIGH, ADDR_CMPB_HIGH,
                ADDR_CAP_HIGH:  s_d.hold   = io_wdata;
                ADDR_CAP_LOW: begin
                    if (cap_is_top) begin
                        s_d.cap = {s_q.hold, io_wdata};
                    end
                end
                ADDR_IRQ_MASK:  s_d.mask = io_wdata[CAP_BIT:OVF_BIT];
                ADDR_IRQ_FLAGS: begin
                    if (io_wdata[CAP_BIT]) begin
                        s_d.capf = 1'b0;
                    end
                    if (io_wdata[OVF_BIT]) begin
                        s_d.ovf = 1'b0;
                    end
                end
                ADDR_COMP_CTRL: s_d.comp_sel = io_wdata[COMP_SEL_POS];
                default: ;
            endcase
        end

        // set beats a clear
        // Applied after the ack and the write-one so the event is kept
        if (ovf_set) begin
            s_d.ovf = 1'b1;
        end

        if (cap_event) begin
            s_d.cap  = s_q.cnt;
            s_d.capf = 1'b1;
        end

        if (rd_low_cnt) begin
            s_d.hold = s_q.cnt[15:8];
        end
        if (rd_low_cap) begin
            s_d.hold = s_q.cap[15:8];
        end

        // Registered read data; unmapped addresses answer zero
        if (io_rd) begin
            unique case (io_addr)
                ADDR_CTRL_A:    s_d.rdata = s_q.ctrl_a;
                ADDR_CTRL_B:    s_d.rdata = s_q.ctrl_b;
                ADDR_CNT_LOW:   s_d.rdata = s_q.cnt[7:0];
                ADDR_CAP_LOW:   s_d.rdata = s_q.cap[7:0];
                ADDR_CNT_HIGH, ADDR_CAP_HIGH:
                                s_d.rdata = s_q.hold;
                ADDR_CMPA_LOW:  s_d.rdata = s_q.cmpa[7:0];
                ADDR_CMPA_HIGH: s_d.rdata = s_q.cmpa[15:8];
                ADDR_CMPB_LOW:  s_d.rdata = s_q.cmpb[7:0];
                ADDR_CMPB_HIGH: s_d.rdata = s_q.cmpb[15:8];
                ADDR_IRQ_MASK:  s_d.rdata = {6'h00, s_q.mask};
                ADDR_IRQ_FLAGS: s_d.rdata = {6'h00, s_q.capf, s_q.ovf};
                ADDR_COMP_CTRL: s_d.rdata = {5'h00, s_q.comp_sel, 2'h0};
                default:        s_d.rdata = RST_BYTE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    // TOP follows the live register, so a new compare or capture value
    // moves the turning point at once
    // top and bottom
    assign top_hit    = (s_q.cnt == top_val);
    assign bottom_hit = (s_q.cnt == CNT_BOTTOM);

    assign capture_irq  = s_q.capf && s_q.mask[CAP_BIT];
    assign overflow_irq = s_q.ovf && s_q.mask[OVF_BIT];

    assign io_rdata            = s_q.rdata;
    assign counter_value       = s_q.cnt;
    assign clock_select_field  = s_q.ctrl_b[CLK_SEL_POS+2:CLK_SEL_POS];
    assign waveform_mode_field = mode;

endmodule : cnt16_capture

// File: tb/cnt16_props.sv
/* Checker for the 16-bit counter, watching only the top-level ports.
   Assumes the CPU leaves one idle cycle between bus accesses. */
`timescale 1ns/1ps
module cnt16_props
    import cnt16_pkg::*;
(
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        ce,
    input wire logic [7:0]  io_addr,
    input wire logic        io_rd,
    input wire logic        io_wr,
    input wire logic [7:0]  io_wdata,
    input wire logic [7:0]  io_rdata,
    input wire logic        timer_tick,
    input wire logic [2:0]  clock_select_field,
    input wire logic [3:0]  waveform_mode_field,
    input wire logic [15:0] counter_value,
    input wire logic        top_hit,
    input wire logic        bottom_hit,
    input wire logic        capture_irq,
    input wire logic        overflow_irq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    // Low-byte write, and a tick that the counter must honour
    wire wr_lo = ce && io_wr && io_addr == ADDR_CNT_LOW;
    wire run   = ce && timer_tick && clock_select_field != 3'h0 && !wr_lo;

    // High byte, idle cycle, then low byte
    sequence s_hi_lo;
        ce && io_wr && io_addr == ADDR_CNT_HIGH ##1 !io_wr ##1 wr_lo;
    endsequence
    property p_pair;
        s_hi_lo |=> counter_value == {$past(io_wdata, 3), $past(io_wdata)};
    endproperty
    property p_idle;
        !run && !wr_lo |=> $stable(counter_value);
    endproperty
    property p_up;
        run && waveform_mode_field == WM_NORMAL
            |=> counter_value == $past(counter_value) + CNT_STEP;
    endproperty
    property p_turn;
        run && waveform_mode_field == WM_PC8 && counter_value == TOP_8BIT
            |=> counter_value == TOP_8BIT - CNT_STEP;
    endproperty
    property p_top;
        waveform_mode_field == WM_NORMAL
            |-> top_hit == (counter_value == CNT_MAX);
    endproperty
    property p_bottom;
        bottom_hit == (counter_value == CNT_BOTTOM);
    endproperty
    property p_reset;
        $fell(sys_rst) |-> counter_value == RST_WORD && !capture_irq
            && !overflow_irq;
    endproperty
    property p_hold;
        !io_rd |=> $stable(io_rdata);
    endproperty

    a_pair: assert property (p_pair) else $error("pair write wrong");
    a_idle: assert property (p_idle) else $error("counter moved");
    a_up: assert property (p_up) else $error("count step wrong");
    a_turn: assert property (p_turn) else $error("no turn at top");
    a_top: assert property (p_top) else $error("top flag wrong");
    a_bottom: assert property (p_bottom) else $error("bottom wrong");
    a_reset: assert property (p_reset) else $error("reset state");
    a_hold: assert property (p_hold) else $error("read data moved");
endmodule : cnt16_props

bind cnt16_capture cnt16_props u_props (
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .io_addr(io_addr),
    .io_rd(io_rd),
    .io_wr(io_wr), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .timer_tick(timer_tick), .clock_select_field(clock_select_field),
    .waveform_mode_field(waveform_mode_field),
    .counter_value(counter_value), .top_hit(top_hit),
    .bottom_hit(bottom_hit), .capture_irq(capture_irq),
    .overflow_irq(overflow_irq)
);

// File: tb/cpu_bus_model.sv
/* Behavioural CPU on the 8-bit I/O bus: byte and 16-bit accesses.
   Assumes the bus answers in one cycle; drives on the falling edge. */
`timescale 1ns/1ps
module cpu_bus_model (
    input  wire logic       clk,
    output logic      [7:0] io_addr,
    output logic            io_rd,
    output logic            io_wr,
    output logic      [7:0] io_wdata,
    input  wire logic [7:0] io_rdata
);
    // Bus idle from time zero
    initial begin
        io_addr = 8'h00;
        io_rd = 1'b0;
        io_wr = 1'b0;
        io_wdata = 8'h00;
    end

    // One write, held across its sampling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        @(posedge clk);
        @(negedge clk);
        io_wr = 1'b0;
        io_wdata = ~d; // Stale data never looks valid
    endtask : wr

    // One read, data taken once the strobe is released
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        io_addr = a;
        io_rd = 1'b1;
        @(posedge clk);
        @(negedge clk);
        io_rd = 1'b0;
        d = io_rdata;
    endtask : rd

    task automatic wr16(input logic [7:0] a, input logic [15:0] v);
        wr(a + 8'h01, v[15:8]);
        wr(a, v[7:0]);
    endtask : wr16

    task automatic rd16(input logic [7:0] a, output logic [15:0] v);
        rd(a, v[7:0]);
        rd(a + 8'h01, v[15:8]);
    endtask : rd16
endmodule : cpu_bus_model

// File: tb/testbench.sv
/* Self-checking bench for cnt16_capture driven through its I/O bus.
   Assumes the CPU model owns the bus; inputs change on falling edges. */
`timescale 1ns/1ps
module testbench
    import cnt16_pkg::*;
    ;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        ce = 1'b1;
    logic        timer_tick = 1'b0;
    logic        capture_pin = 1'b0;
    logic        comparator_output = 1'b0;
    logic        capture_irq_ack = 1'b0;
    logic        overflow_irq_ack = 1'b0;
    logic [7:0]  io_addr, io_wdata, io_rdata, b;
    logic        io_rd, io_wr, capture_irq, overflow_irq, top_hit, bottom_hit;
    logic [2:0]  clock_select_field;
    logic [3:0]  waveform_mode_field;
    logic [15:0] counter_value, v;
    int          mismatches = 0;
    int          num_checks = 0;
    int          cycles = 0;

    always #50 clk = ~clk;

    cnt16_capture u_dut (
        .clk(clk), .sys_rst(sys_rst), .ce(ce), .io_addr(io_addr),
        .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata),
        .io_rdata(io_rdata), .timer_tick(timer_tick),
        .clock_select_field(clock_select_field),
        .waveform_mode_field(waveform_mode_field),
        .capture_pin(capture_pin), .comparator_output(comparator_output),
        .capture_irq(capture_irq), .overflow_irq(overflow_irq),
        .capture_irq_ack(capture_irq_ack),
        .overflow_irq_ack(overflow_irq_ack),
        .counter_value(counter_value), .top_hit(top_hit),
        .bottom_hit(bottom_hit)
    );
    cpu_bus_model u_cpu (
        .clk(clk), .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr),
        .io_wdata(io_wdata), .io_rdata(io_rdata)
    );

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Consecutive ticks, then idle
    task automatic tick(input int n);
        repeat (n) begin
            @(negedge clk);
            timer_tick = 1'b1;
        end
        @(negedge clk);
        timer_tick = 1'b0;
    endtask : tick

    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test

    // Hang guard, far above the few hundred cycles needed
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches = mismatches + 1;
            stop_test();
        end
    end

    initial begin
        repeat (16) @(negedge clk);
        sys_rst = 1'b0;
        chk(counter_value, 16'h0000);
        chk(16'(bottom_hit), 16'h0001);
        u_cpu.rd16(ADDR_CAP_LOW, v);
        chk(v, 16'h0000);
        $display("test reset done");
        u_cpu.wr16(ADDR_CNT_LOW, 16'h01ff);
        chk(counter_value, 16'h01ff);
        u_cpu.rd16(ADDR_CNT_LOW, v);
        chk(v, 16'h01ff);
        u_cpu.wr(ADDR_CMPA_HIGH, 8'h55);
        u_cpu.wr(ADDR_CMPA_LOW, 8'h20);
        u_cpu.wr(ADDR_CNT_LOW, 8'h10);
        chk(counter_value, 16'h5510);
        u_cpu.wr16(ADDR_CNT_LOW, 16'h7710);
        u_cpu.rd16(ADDR_CMPA_LOW, v);
        chk(v, 16'h5520);
        u_cpu.rd(ADDR_CNT_HIGH, b);
        chk(16'(b), 16'h0077);
        $display("test holding done");
        tick(3);
        chk(counter_value, 16'h7710);
        u_cpu.wr(ADDR_CTRL_B, 8'h01);
        tick(3);
        chk(counter_value, 16'h7713);
        fork
            tick(1);
            u_cpu.wr(ADDR_CNT_LOW, 8'h00);
        join
        chk(counter_value, 16'h7700);
        // Clock enable low freezes the counter despite ticks
        ce = 1'b0;
        tick(2);
        ce = 1'b1;
        chk(counter_value, 16'h7700);
        u_cpu.wr(ADDR_IRQ_MASK, 8'h03);
        u_cpu.wr16(ADDR_CNT_LOW, 16'hffff);
        chk(16'(top_hit), 16'h0001);
        // Ack in the cycle of the wrap: the set must win
        fork
            tick(1);
            begin
                @(negedge clk) overflow_irq_ack = 1'b1;
                @(negedge clk) overflow_irq_ack = 1'b0;
            end
        join
        chk(counter_value, 16'h0000);
        chk(16'(overflow_irq), 16'h0001);
        @(negedge clk) overflow_irq_ack = 1'b1;
        @(negedge clk) overflow_irq_ack = 1'b0;
        chk(16'(overflow_irq), 16'h0000);
        u_cpu.wr(ADDR_CTRL_A, 8'h01);
        u_cpu.wr16(ADDR_CNT_LOW, 16'h00ff);
        tick(2);
        chk(counter_value, 16'h00fd);
        u_cpu.wr16(ADDR_CNT_LOW, 16'h0001);
        tick(2);
        chk(counter_value, 16'h0001);
        chk(16'(overflow_irq), 16'h0001);
        u_cpu.wr(ADDR_IRQ_FLAGS, 8'h01);
        chk(16'(overflow_irq), 16'h0000);
        $display("test counting done");
        u_cpu.wr(ADDR_CTRL_A, 8'h00);
        u_cpu.wr(ADDR_CTRL_B, 8'h40);
        u_cpu.wr16(ADDR_CNT_LOW, 16'h1234);
        @(negedge clk) capture_pin = 1'b1;
        repeat (6) @(negedge clk);
        chk(16'(capture_irq), 16'h0001);
        u_cpu.rd16(ADDR_CAP_LOW, v);
        chk(v, 16'h1234);
        u_cpu.wr16(ADDR_CAP_LOW, 16'h9999);
        u_cpu.rd16(ADDR_CAP_LOW, v);
        chk(v, 16'h1234);
        u_cpu.wr(ADDR_IRQ_FLAGS, 8'h00);
        chk(16'(capture_irq), 16'h0001);
        u_cpu.wr(ADDR_IRQ_FLAGS, 8'h02);
        chk(16'(capture_irq), 16'h0000);
        capture_pin = 1'b0;
        repeat (6) @(negedge clk);
        chk(16'(capture_irq), 16'h0000);
        u_cpu.wr(ADDR_CTRL_B, 8'hc0);
        capture_pin = 1'b1;
        repeat (2) @(negedge clk);
        capture_pin = 1'b0;
        repeat (10) @(negedge clk);
        chk(16'(capture_irq), 16'h0000);
        // Unfiltered copy lands four edges after the pin, filtered eight
        capture_pin = 1'b1;
        repeat (7) @(negedge clk);
        chk(16'(capture_irq), 16'h0000);
        @(negedge clk);
        chk(16'(capture_irq), 16'h0001);
        capture_irq_ack = 1'b1;
        @(negedge clk) capture_irq_ack = 1'b0;
        chk(16'(capture_irq), 16'h0000);
        $display("test capture done");
        u_cpu.wr(ADDR_CTRL_B, 8'h40);
        u_cpu.wr(ADDR_COMP_CTRL, 8'h04);
        u_cpu.wr(ADDR_IRQ_FLAGS, 8'h02);
        comparator_output = 1'b1;
        repeat (6) @(negedge clk);
        chk(16'(capture_irq), 16'h0001);
        u_cpu.wr(ADDR_IRQ_FLAGS, 8'h02);
        u_cpu.wr(ADDR_CTRL_B, 8'h58);
        u_cpu.wr16(ADDR_CAP_LOW, 16'h0040);
        u_cpu.rd16(ADDR_CAP_LOW, v);
        chk(v, 16'h0040);
        comparator_output = 1'b0;
        repeat (6) @(negedge clk);
        comparator_output = 1'b1;
        repeat (6) @(negedge clk);
        chk(16'(capture_irq), 16'h0000);
        $display("test source done");
        stop_test();
    end
endmodule : testbench
